// ---- fpec_pkg.sv ----
package fpec_pkg;
  // flash geometry
  localparam int FLASH_ADDR_W = 15;
  localparam int PAGE_BITS    = 9;
  localparam int PAGE_BYTES   = 512;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // key codes, in the order they must arrive
  localparam logic [7:0] KEY_FIRST  = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;

  // clock and self-timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS  = 40000;
  localparam int ERASE_TIME_NS = 20000000;
  localparam int PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES  =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reset value of the error indicator after power-on
  localparam logic ERR_FLAG_RESET = 1'b0;

  typedef enum logic [1:0] {
    OP_BYTE,
    OP_PAIR,
    OP_ERASE
  } fpec_op_e;

  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_HALF,
    KEY_ARMED,
    KEY_DEAD
  } fpec_key_e;

  typedef enum logic {
    SEQ_IDLE,
    SEQ_WAIT
  } fpec_seq_e;
endpackage : fpec_pkg

// ---- fpec_array_if.sv ----
`timescale 1ns/1ps
interface fpec_array_if #(
  parameter int AW = 15
);
  import fpec_pkg::*;
  logic           start;
  fpec_op_e       op;
  logic [AW-1:0]  addr;
  logic [7:0]     data0;
  logic [7:0]     data1;
  logic           busy;
  logic           done;

  modport seq (
    output start,
    output op,
    output addr,
    output data0,
    output data1,
    input  busy,
    input  done
  );

  modport arr (
    input  start,
    input  op,
    input  addr,
    input  data0,
    input  data1,
    output busy,
    output done
  );
endinterface : fpec_array_if

// ---- fpec_flash_array.sv ----
`timescale 1ns/1ps
module fpec_flash_array #(
  parameter int AW           = fpec_pkg::FLASH_ADDR_W,
  parameter int PROG_CYCLES  = fpec_pkg::PROG_CYCLES,
  parameter int ERASE_CYCLES = fpec_pkg::ERASE_CYCLES
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  // command from the sequencer
  fpec_array_if.arr          cmd,
  // fetch read port
  input  wire logic [AW-1:0] readAddr,
  output logic      [7:0]    readData
);
  import fpec_pkg::*;

  logic [7:0] mem [2**AW];

  logic           busy_reg,  busy_next;
  logic           done_reg,  done_next;
  logic [31:0]    timer_reg, timer_next;
  logic [9:0]     eraseCnt_reg, eraseCnt_next;
  fpec_op_e       op_reg,    op_next;
  logic [AW-1:0]  addr_reg,  addr_next;
  logic [7:0]     d0_reg,    d0_next;
  logic [7:0]     d1_reg,    d1_next;
  logic [7:0]     readData_reg;
  logic           wrEn0, wrEn1;
  logic [AW-1:0]  wrAddr0, wrAddr1;
  logic [7:0]     wrData0, wrData1;

  assign cmd.busy = busy_reg;
  assign cmd.done = done_reg;
  assign readData = readData_reg;

  always_comb begin
    busy_next     = busy_reg;
    done_next     = 1'b0;
    timer_next    = timer_reg;
    eraseCnt_next = eraseCnt_reg;
    op_next       = op_reg;
    addr_next     = addr_reg;
    d0_next       = d0_reg;
    d1_next       = d1_reg;
    wrEn0         = 1'b0;
    wrEn1         = 1'b0;
    wrAddr0       = addr_reg;
    wrAddr1       = addr_reg | AW'(1);
    wrData0       = mem[addr_reg] & d0_reg;
    wrData1       = mem[addr_reg | AW'(1)] & d1_reg;
    if (!busy_reg) begin
      if (cmd.start) begin
        busy_next     = 1'b1;
        op_next       = cmd.op;
        addr_next     = cmd.addr;
        d0_next       = cmd.data0;
        d1_next       = cmd.data1;
        eraseCnt_next = '0;
        // pair and byte share one duration
        timer_next    = (cmd.op == OP_ERASE) ?
                        32'(ERASE_CYCLES - 1) : 32'(PROG_CYCLES - 1);
      end
    end else begin
      // erase walks the page one byte per cycle
      if (op_reg == OP_ERASE && eraseCnt_reg < 10'(PAGE_BYTES)) begin
        wrEn0         = 1'b1;
        wrAddr0       = {addr_reg[AW-1:PAGE_BITS],
                         eraseCnt_reg[PAGE_BITS-1:0]};
        wrData0       = ERASED_BYTE;
        eraseCnt_next = eraseCnt_reg + 10'h001;
      end
      if (timer_reg == 32'h0000_0000) begin
        busy_next = 1'b0;
        done_next = 1'b1;
        if (op_reg != OP_ERASE) begin
          wrEn0 = 1'b1;
          wrEn1 = (op_reg == OP_PAIR);
        end
      end else begin
        timer_next = timer_reg - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_reg     <= 1'b0;
      done_reg     <= 1'b0;
      timer_reg    <= '0;
      eraseCnt_reg <= '0;
      op_reg       <= OP_BYTE;
      addr_reg     <= '0;
      d0_reg       <= ERASED_BYTE;
      d1_reg       <= ERASED_BYTE;
    end else begin
      busy_reg     <= busy_next;
      done_reg     <= done_next;
      timer_reg    <= timer_next;
      eraseCnt_reg <= eraseCnt_next;
      op_reg       <= op_next;
      addr_reg     <= addr_next;
      d0_reg       <= d0_next;
      d1_reg       <= d1_next;
    end
  end

  // contents survive reset
  always_ff @(posedge core_clk) begin
    if (wrEn0) begin
      mem[wrAddr0] <= wrData0;
    end
    if (wrEn1) begin
      mem[wrAddr1] <= wrData1;
    end
    readData_reg <= mem[readAddr];
  end
endmodule : fpec_flash_array

// ---- fpec_flash_program_erase_control.sv ----
`timescale 1ns/1ps
module fpec_flash_program_erase_control #(
  parameter int PROG_CYCLES  = fpec_pkg::PROG_CYCLES,
  parameter int ERASE_CYCLES = fpec_pkg::ERASE_CYCLES
) (
  // clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              powerOnReset,
  // external data writes from the core
  input  wire logic                              xdataWrite,
  input  wire logic [15:0]                       xdataAddr,
  input  wire logic [7:0]                        xdataData,
  // key register writes
  input  wire logic                              keyWrite,
  input  wire logic [7:0]                        keyData,
  // control levels
  input  wire logic                              storeWriteEnable,
  input  wire logic                              storeEraseEnable,
  input  wire logic                              blockWriteSelect,
  input  wire logic                              supplyMonitorOn,
  input  wire logic                              supplyMonitorResetOn,
  // instruction fetch
  input  wire logic [fpec_pkg::FLASH_ADDR_W-1:0] fetchAddr,
  output logic      [7:0]                        fetchData,
  // status
  output logic                                   xdataToFlash,
  output logic                                   cpuStall,
  output logic                                   flashErrorReset,
  output logic                                   flashErrorFlag,
  output logic                                   keyArmed,
  output logic                                   flashDisabled
);
  import fpec_pkg::*;
  localparam int AW = FLASH_ADDR_W;

  if (PROG_CYCLES < 1 || ERASE_CYCLES < PAGE_BYTES + 1) begin : gChk
    $error("erase must outlast the page walk; program needs a cycle");
  end

  fpec_array_if #(.AW(AW)) arrBus ();

  fpec_key_e      key_reg,      key_next;
  fpec_seq_e      seq_reg,      seq_next;
  logic           start_reg,    start_next;
  fpec_op_e       op_reg,       op_next;
  logic [AW-1:0]  addr_reg,     addr_next;
  logic [7:0]     d0_reg,       d0_next;
  logic [7:0]     d1_reg,       d1_next;
  logic           evenPend_reg, evenPend_next;
  logic [AW-1:0]  evenAddr_reg, evenAddr_next;
  logic [7:0]     evenData_reg, evenData_next;
  logic           stall_reg,    stall_next;
  logic           errRst_reg,   errRst_next;
  logic           errFlag_reg,  errFlag_next;
  logic           toFlash_reg,  toFlash_next;
  logic           armed_reg,    armed_next;
  logic           dead_reg,     dead_next;
  logic [AW-1:0]  wrAddr;
  logic           attempt;

  assign wrAddr  = xdataAddr[AW-1:0];
  // a write reaches flash only while write enable is set
  assign attempt = xdataWrite && storeWriteEnable
                   && seq_reg == SEQ_IDLE;

  assign arrBus.start = start_reg;
  assign arrBus.op    = op_reg;
  assign arrBus.addr  = addr_reg;
  assign arrBus.data0 = d0_reg;
  assign arrBus.data1 = d1_reg;

  always_comb begin
    key_next      = key_reg;
    seq_next      = seq_reg;
    start_next    = 1'b0;
    op_next       = op_reg;
    addr_next     = addr_reg;
    d0_next       = d0_reg;
    d1_next       = d1_reg;
    evenPend_next = evenPend_reg;
    evenAddr_next = evenAddr_reg;
    evenData_next = evenData_reg;
    stall_next    = stall_reg;
    errRst_next   = 1'b0;
    errFlag_next  = errFlag_reg | errRst_reg;
    // hardware only mirrors the enable, never clears it
    toFlash_next  = storeWriteEnable;

    // key checker: order and value only, no timeout
    if (keyWrite) begin
      case (key_reg)
        KEY_LOCKED: begin
          key_next = (keyData == KEY_FIRST) ? KEY_HALF : KEY_DEAD;
        end
        KEY_HALF: begin
          key_next = (keyData == KEY_SECOND) ? KEY_ARMED : KEY_DEAD;
        end
        default: begin
          key_next = KEY_DEAD;
        end
      endcase
    end

    case (seq_reg)
      SEQ_IDLE: begin
        if (attempt) begin
          if (!(supplyMonitorOn && supplyMonitorResetOn)) begin
            // nothing is sent to the array
            errRst_next = 1'b1;
          end else if (key_reg != KEY_ARMED) begin
            key_next = KEY_DEAD;
          end else begin
            key_next = KEY_LOCKED;
            if (storeEraseEnable) begin
              start_next = 1'b1;
              op_next    = OP_ERASE;
              addr_next  = wrAddr;
              seq_next   = SEQ_WAIT;
              stall_next = 1'b1;
            end else if (blockWriteSelect && !wrAddr[0]) begin
              // even byte only latched
              evenPend_next = 1'b1;
              evenAddr_next = wrAddr;
              evenData_next = xdataData;
            end else if (blockWriteSelect) begin
              start_next    = 1'b1;
              op_next       = OP_PAIR;
              addr_next     = {wrAddr[AW-1:1], 1'b0};
              d0_next       = (evenPend_reg &&
                               evenAddr_reg[AW-1:1] == wrAddr[AW-1:1]) ?
                              evenData_reg : ERASED_BYTE;
              d1_next       = xdataData;
              evenPend_next = 1'b0;
              seq_next      = SEQ_WAIT;
              stall_next    = 1'b1;
            end else begin
              start_next = 1'b1;
              op_next    = OP_BYTE;
              addr_next  = wrAddr;
              d0_next    = xdataData;
              d1_next    = ERASED_BYTE;
              seq_next   = SEQ_WAIT;
              stall_next = 1'b1;
            end
          end
        end
      end
      SEQ_WAIT: begin
        if (arrBus.done) begin
          seq_next   = SEQ_IDLE;
          stall_next = 1'b0;
        end
      end
      default: begin
        seq_next   = SEQ_IDLE;
        stall_next = 1'b0;
      end
    endcase

    armed_next = (key_next == KEY_ARMED);
    dead_next  = (key_next == KEY_DEAD);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      key_reg      <= KEY_LOCKED;
      seq_reg      <= SEQ_IDLE;
      start_reg    <= 1'b0;
      op_reg       <= OP_BYTE;
      addr_reg     <= '0;
      d0_reg       <= ERASED_BYTE;
      d1_reg       <= ERASED_BYTE;
      evenPend_reg <= 1'b0;
      evenAddr_reg <= '0;
      evenData_reg <= ERASED_BYTE;
      stall_reg    <= 1'b0;
      errRst_reg   <= 1'b0;
      // indicator survives every reset but power-on
      errFlag_reg  <= powerOnReset ? ERR_FLAG_RESET
                                   : (errFlag_reg | errRst_reg);
      toFlash_reg  <= 1'b0;
      armed_reg    <= 1'b0;
      dead_reg     <= 1'b0;
    end else begin
      key_reg      <= key_next;
      seq_reg      <= seq_next;
      start_reg    <= start_next;
      op_reg       <= op_next;
      addr_reg     <= addr_next;
      d0_reg       <= d0_next;
      d1_reg       <= d1_next;
      evenPend_reg <= evenPend_next;
      evenAddr_reg <= evenAddr_next;
      evenData_reg <= evenData_next;
      stall_reg    <= stall_next;
      errRst_reg   <= errRst_next;
      errFlag_reg  <= errFlag_next;
      toFlash_reg  <= toFlash_next;
      armed_reg    <= armed_next;
      dead_reg     <= dead_next;
    end
  end

  fpec_flash_array #(
    .AW           (AW),
    .PROG_CYCLES  (PROG_CYCLES),
    .ERASE_CYCLES (ERASE_CYCLES)
  ) uArray (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .cmd      (arrBus.arr),
    .readAddr (fetchAddr),
    .readData (fetchData)
  );

  assign xdataToFlash    = toFlash_reg;
  assign cpuStall        = stall_reg;
  assign flashErrorReset = errRst_reg;
  assign flashErrorFlag  = errFlag_reg;
  assign keyArmed        = armed_reg;
  assign flashDisabled   = dead_reg;
endmodule : fpec_flash_program_erase_control

// ---- fpec_asserts.sv ----
`timescale 1ns/1ps
module fpec_asserts
  import fpec_pkg::*;
#(
  parameter int PROG_CYCLES  = 4,
  parameter int ERASE_CYCLES = 520
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // requests
  input wire logic        xdataWrite,
  input wire logic [15:0] xdataAddr,
  input wire logic        keyWrite,
  input wire logic [7:0]  keyData,
  // control levels
  input wire logic        storeWriteEnable,
  input wire logic        storeEraseEnable,
  input wire logic        blockWriteSelect,
  input wire logic        supplyMonitorOn,
  input wire logic        supplyMonitorResetOn,
  // status
  input wire logic        xdataToFlash,
  input wire logic        cpuStall,
  input wire logic        flashErrorReset,
  input wire logic        flashErrorFlag,
  input wire logic        keyArmed,
  input wire logic        flashDisabled
);
  logic        attempt;
  logic        supplyOk;
  logic [19:0] stallCnt_reg;
  logic [19:0] stallCnt_next;

  assign attempt  = xdataWrite && storeWriteEnable && !cpuStall;
  assign supplyOk = supplyMonitorOn && supplyMonitorResetOn;

  // length of the current busy span
  always_comb begin
    stallCnt_next = (cpuStall && !sys_rst) ? stallCnt_reg + 20'h1 : 20'h0;
  end
  always_ff @(posedge core_clk) begin
    stallCnt_reg <= stallCnt_next;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  err_pulse_a:
    assert property (flashErrorReset |=> !flashErrorReset && flashErrorFlag)
      else $error("error reset pulse or flag wrong");
  mon_off_a:
    assert property (attempt && !flashDisabled && !supplyOk |=>
      flashErrorReset) else $error("no error reset with monitor off");
  no_key_a:
    assert property (attempt && supplyOk && !keyArmed |=> flashDisabled)
      else $error("unkeyed attempt not locked out");
  relock_a:
    assert property (attempt && supplyOk && keyArmed |=> !keyArmed)
      else $error("key not relocked");
  op_stall_a:
    assert property (attempt && supplyOk && keyArmed && (storeEraseEnable
      || !blockWriteSelect || xdataAddr[0]) |=> cpuStall)
      else $error("operation did not stall core");
  stall_len_a:
    assert property ($fell(cpuStall) |-> stallCnt_reg == PROG_CYCLES + 2
      || stallCnt_reg == ERASE_CYCLES + 2) else $error("busy span wrong");
  route_a:
    assert property (!sys_rst |=> xdataToFlash == $past(storeWriteEnable))
      else $error("routing flag wrong");
  arm_after_a:
    assert property ($rose(keyArmed) |-> $past(keyWrite)
      && $past(keyData) == KEY_SECOND) else $error("armed without key");

  cover property ($fell(cpuStall));
  cover property (flashErrorReset);
  cover property ($rose(flashDisabled));
endmodule : fpec_asserts

bind fpec_flash_program_erase_control fpec_asserts #(
  .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)
) chk_u (
  .core_clk             (core_clk),
  .sys_rst              (sys_rst),
  .xdataWrite           (xdataWrite),
  .xdataAddr            (xdataAddr),
  .keyWrite             (keyWrite),
  .keyData              (keyData),
  .storeWriteEnable     (storeWriteEnable),
  .storeEraseEnable     (storeEraseEnable),
  .blockWriteSelect     (blockWriteSelect),
  .supplyMonitorOn      (supplyMonitorOn),
  .supplyMonitorResetOn (supplyMonitorResetOn),
  .xdataToFlash         (xdataToFlash),
  .cpuStall             (cpuStall),
  .flashErrorReset      (flashErrorReset),
  .flashErrorFlag       (flashErrorFlag),
  .keyArmed             (keyArmed),
  .flashDisabled        (flashDisabled)
);

// ---- fpec_core_model.sv ----
`timescale 1ns/1ps
module fpec_core_model (
  // clock
  input  wire logic        core_clk,
  // key register writes
  output logic             keyWrite,
  output logic [7:0]       keyData,
  // external data writes
  output logic             xdataWrite,
  output logic [15:0]      xdataAddr,
  output logic [7:0]       xdataData
);
  initial begin
    {keyWrite, xdataWrite} = 2'b00;
    {keyData, xdataData} = 16'h0000;
    xdataAddr = 16'h0000;
  end
  // released lines show the inverse of the last value
  task automatic put_key(input logic [7:0] k);
    @(posedge core_clk);
    keyWrite <= 1'b1;
    keyData  <= k;
    @(posedge core_clk);
    keyWrite <= 1'b0;
    keyData  <= ~k;
  endtask : put_key
  // the model takes no interrupts inside a key and write sequence
  // two codes with any spacing, repeated for every byte
  task automatic unlock(input logic [7:0] k0, k1, input int gap);
    put_key(k0);
    repeat (gap) @(posedge core_clk);
    put_key(k1);
  endtask : unlock
  // one write; block bytes go even first, odd second
  task automatic write(input logic [15:0] wa, input logic [7:0] wd);
    @(posedge core_clk);
    xdataWrite <= 1'b1;
    xdataAddr  <= wa;
    xdataData  <= wd;
    @(posedge core_clk);
    xdataWrite <= 1'b0;
    xdataAddr  <= ~wa;
    xdataData  <= ~wd;
  endtask : write
endmodule : fpec_core_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import fpec_pkg::*;
  localparam int PC = 4;
  localparam int EC = 520;
  logic        core_clk, sys_rst, powerOnReset, keyWrite, xdataWrite;
  logic        storeWriteEnable, storeEraseEnable, blockWriteSelect;
  logic        supplyMonitorOn, supplyMonitorResetOn, xdataToFlash;
  logic        cpuStall, flashErrorReset, flashErrorFlag, keyArmed;
  logic        flashDisabled;
  logic [7:0]  keyData, xdataData, fetchData, d;
  logic [15:0] xdataAddr, a;
  logic [14:0] fetchAddr;
  logic [7:0]  mem [int];
  int          fails, compares, seed, n;

  fpec_core_model core_u (.core_clk(core_clk), .keyWrite(keyWrite),
    .keyData(keyData), .xdataWrite(xdataWrite), .xdataAddr(xdataAddr),
    .xdataData(xdataData));
  fpec_flash_program_erase_control #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC))
  dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .powerOnReset(powerOnReset), .xdataWrite(xdataWrite),
    .xdataAddr(xdataAddr), .xdataData(xdataData), .keyWrite(keyWrite),
    .keyData(keyData), .storeWriteEnable(storeWriteEnable),
    .storeEraseEnable(storeEraseEnable),
    .blockWriteSelect(blockWriteSelect), .supplyMonitorOn(supplyMonitorOn),
    .supplyMonitorResetOn(supplyMonitorResetOn), .fetchAddr(fetchAddr),
    .fetchData(fetchData), .xdataToFlash(xdataToFlash),
    .cpuStall(cpuStall), .flashErrorReset(flashErrorReset),
    .flashErrorFlag(flashErrorFlag), .keyArmed(keyArmed),
    .flashDisabled(flashDisabled));

  task automatic chk(input logic [31:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  // {write en, erase en, block sel, monitor, monitor reset}
  task automatic ctl(input logic [4:0] c);
    @(posedge core_clk);
    {storeWriteEnable, storeEraseEnable, blockWriteSelect} <= c[4:2];
    {supplyMonitorOn, supplyMonitorResetOn} <= c[1:0];
  endtask : ctl
  // write, then count cycles until the core is released
  task automatic op(input logic [15:0] wa, input logic [7:0] wd, int exp);
    core_u.write(wa, wd);
    n = 0;
    do begin
      tick();
      n++;
    end while (cpuStall === 1'b1 && n < EC + 9);
    chk(n, exp, "busy cycles");
  endtask : op
  task automatic rd(input logic [15:0] ra);
    @(posedge core_clk);
    fetchAddr <= ra[14:0];
    tick();
    chk(fetchData, mem[ra], "fetch");
  endtask : rd
  task automatic rst(input logic por);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    powerOnReset <= por;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    powerOnReset <= 1'b0;
    tick();
  endtask : rst

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (10000) @(posedge core_clk);
    fails++;
    test_done();
  end
  initial begin
    {sys_rst, powerOnReset, storeWriteEnable, storeEraseEnable} = 4'hc;
    {blockWriteSelect, supplyMonitorOn, supplyMonitorResetOn} = 3'h0;
    fetchAddr = 15'h0000;
    seed = 89;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    powerOnReset <= 1'b0;
    tick();
    chk(flashErrorFlag, 1'b0, "flag after power on");
    ctl(5'h1b);
    core_u.unlock(KEY_FIRST, KEY_SECOND, 37);
    tick();
    chk(keyArmed, 1'b1, "armed");
    a = 16'h0200 | 16'($random(seed) & 32'h1ff);
    op(a, 8'($random(seed)), EC + 2);
    chk(keyArmed, 1'b0, "relocked");
    chk(xdataToFlash, 1'b1, "routing kept");
    for (int i = 512; i < 1024; i++) mem[i] = ERASED_BYTE;
    for (int i = 512; i < 1024; i++) rd(16'(i));
    ctl(5'h13);
    for (int k = 0; k < 4; k++) begin
      a = (k < 2) ? 16'h0210 : 16'h0200 | 16'($random(seed) & 32'h1ff);
      d = 8'($random(seed));
      core_u.unlock(KEY_FIRST, KEY_SECOND, k);
      op(a, d, PC + 2);
      mem[a] = mem[a] & d;
      rd(a);
    end
    ctl(5'h17);
    for (int k = 0; k < 2; k++) begin
      a = 16'h0240 + 16'(4 * k);
      d = 8'($random(seed));
      core_u.unlock(KEY_FIRST, KEY_SECOND, 0);
      op(a, d, 1);
      mem[a] = mem[a] & d;
      d = 8'($random(seed));
      core_u.unlock(KEY_FIRST, KEY_SECOND, 0);
      op(a + 16'h1, d, PC + 2);
      mem[a + 16'h1] = mem[a + 16'h1] & d;
      rd(a);
      rd(a + 16'h1);
    end
    ctl(5'h03);
    tick();
    chk(xdataToFlash, 1'b0, "routing off");
    op(16'h0210, 8'h00, 1);
    rd(16'h0210);
    for (int m = 0; m < 2; m++) begin
      ctl({3'b100, m[0], ~m[0]});
      core_u.write(16'h0210, 8'h00);
      #1;
      chk(flashErrorReset, 1'b1, "error reset");
      tick();
      chk({flashErrorReset, flashErrorFlag, cpuStall}, 3'h2, "err");
      rd(16'h0210);
    end
    rst(1'b0);
    chk(flashErrorFlag, 1'b1, "flag kept");
    ctl(5'h13);
    op(16'h0220, 8'h00, 1);
    chk(flashDisabled, 1'b1, "locked out");
    core_u.unlock(KEY_FIRST, KEY_SECOND, 0);
    op(16'h0220, 8'h00, 1);
    chk(keyArmed, 1'b0, "stays locked");
    rd(16'h0220);
    for (int k = 0; k < 2; k++) begin
      rst(1'b1);
      chk({flashErrorFlag, flashDisabled}, 2'b00, "after reset");
      core_u.unlock(k ? KEY_FIRST : KEY_SECOND, k ? 8'h00 : KEY_FIRST, 3);
      tick();
      chk({keyArmed, flashDisabled}, 2'b01, "bad key");
    end
    test_done();
  end
endmodule : testbench
